// ### design/dma_ctrl_pkg.sv
// package: register map, field positions and carrier structs of the ping-pong dma control
package dma_ctrl_pkg;

    localparam logic [15:0] TX_CNT_OFFSET = 16'hc828;
    localparam logic [15:0] STATUS_OFFSET = 16'hc82c;
    localparam logic [15:0] CONTROL_OFFSET = 16'hc830;
    localparam logic [31:0] REG_RESET_VALUE = 32'h00000000;
    localparam logic [31:0] UNMAPPED_READ_VALUE = 32'h00000000;

    // status field positions
    localparam int ST_SAVED_LSB = 10;
    localparam int ST_FE_A = 8;
    localparam int ST_PE_A = 6;
    localparam int ST_OVR_A = 4;
    localparam int ST_TX_ACT_A = 2;
    localparam int ST_RX_ACT_A = 0;

    // control field positions
    localparam int CR_TX_RST = 5;
    localparam int CR_RX_RST = 4;
    localparam int CR_TX_LOAD_A = 2;
    localparam int CR_RX_LOAD_A = 0;

    localparam int CNT_W = 13;

    // saved-count status codes
    localparam logic [2:0] SAVED_NONE = 3'h0;
    localparam logic [2:0] SAVED_ONCE = 3'h2;
    localparam logic [2:0] SAVED_MANY = 3'h6;

    // register port carrier
    typedef struct packed {
        logic [15:0] addr;
        logic [31:0] wdata;
        logic wr;
        logic rd;
    } reg_req_s;

    // one byte taken from the receive fifo by the active buffer
    typedef struct packed {
        logic valid;
        logic frame_err;
        logic parity_err;
        logic overrun;
    } rx_byte_s;

    typedef enum logic [1:0] {
        CH_IDLE,
        CH_BUF_A,
        CH_BUF_B
    } chan_state_e;

endpackage : dma_ctrl_pkg

// ### design/serial_ping_pong_dma_ctrl.sv
// serial controller two-buffer dma: control, status and transmit counter
//
// What this block does
// [R1] tx counter gives offset in active buffer
// [R2] tx counter zeroed on load and tx reset
// [R3] saved-count status codes 0,2,3,6,7
// [R4] saved-count status cleared on rx load/reset
// [R5] frame error flag set per receiving buffer
// [R6] parity error flag set per receiving buffer
// [R7] error flags held until reload or reset
// [R8] second controller reads error flags as zero
// [R9] overrun passed to next loaded buffer
// [R10] overrun flag cleared on reload or reset
// [R11] tx active flags follow processed buffer
// [R12] rx active flags follow processed buffer
// [R13] tx reset bit resets tx, self clears
// [R14] rx reset bit resets rx and status
// [R15] load bit latches addresses, enables buffer
// [R16] simultaneous load processes buffer a first
// [R17] zero write no effect; done clears load
// [R18] load bit reads pending or active
// [R19] count saved only on first deassertion
// [R20] finished buffer hands over to loaded other
module serial_ping_pong_dma_ctrl
    import dma_ctrl_pkg::*;
#(
    parameter bit SECOND_CONTROLLER = 1'b0
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire reg_req_s reg_req,
    output logic [31:0] rdata,
    // transmit side: one pulse per byte fetched, one pulse at buffer end
    input wire logic tx_byte_fetched,
    input wire logic tx_buf_done,
    // receive side
    input wire rx_byte_s rx_byte,
    input wire logic rx_buf_done,
    input wire logic rx_fifo_overflow,
    input wire logic spi_slave_mode,
    input wire logic slave_select_n,
    // begin/end address latch strobes towards the address registers
    output logic [3:0] addr_latch,
    output logic tx_active_a,
    output logic tx_active_b,
    output logic rx_active_a,
    output logic rx_active_b,
    output logic tx_chan_reset,
    output logic rx_chan_reset,
    output logic save_rx_count
);

    typedef struct packed {
        logic [31:0] rdata;
        chan_state_e tx_state;
        chan_state_e rx_state;
        logic [1:0] tx_load;
        logic [1:0] rx_load;
        logic [CNT_W-1:0] tx_cnt;
        logic [2:0] saved_status;
        logic [1:0] frame_err;
        logic [1:0] parity_err;
        logic [1:0] overrun;
        logic overrun_pending;
        logic ssel_seen_reg;
        logic [3:0] addr_latch;
        logic tx_rst;
        logic rx_rst;
        logic save_pulse;
        logic [3:0] act;
    } state_s;

    state_s state_reg;
    state_s state_next;

    // combinational next state of the whole block
    always_comb begin
        // per-cycle decode, not stored
        logic wr_ctrl;
        logic [1:0] tx_set;
        logic [1:0] rx_set;
        logic do_tx_rst;
        logic do_rx_rst;
        logic ssel_fall;
        logic [31:0] status_word;
        logic rx_a;
        logic rx_b;
        logic [1:0] rx_sel;
        logic tx_busy;
        logic rx_busy;

        // defaults: every field holds, locals start clean
        state_next = state_reg;
        wr_ctrl = 1'b0;
        tx_set = 2'h0;
        rx_set = 2'h0;
        do_tx_rst = 1'b0;
        do_rx_rst = 1'b0;
        ssel_fall = 1'b0;
        status_word = '0;
        rx_a = 1'b0;
        rx_b = 1'b0;
        rx_sel = 2'h0;
        tx_busy = 1'b0;
        rx_busy = 1'b0;

        // control word decode; other addresses are read-only or unmapped
        // a write and a read never share a cycle, so reads have no side effect
        wr_ctrl = reg_req.wr && (reg_req.addr == CONTROL_OFFSET);
        do_tx_rst = wr_ctrl && reg_req.wdata[CR_TX_RST]; // [R13]
        do_rx_rst = wr_ctrl && reg_req.wdata[CR_RX_RST]; // [R14]

        // only ones load; zero writes leave the bits alone
        if (wr_ctrl) begin
            tx_set = reg_req.wdata[CR_TX_LOAD_A +: 2]; // [R17]
            rx_set = reg_req.wdata[CR_RX_LOAD_A +: 2]; // [R17]
        end

        // which buffer of each direction is being worked on
        // rx_sel is one-hot or zero, used as a mask for the flag sets
        rx_a = state_reg.rx_state == CH_BUF_A;
        rx_b = state_reg.rx_state == CH_BUF_B;
        rx_sel = {rx_b, rx_a};
        tx_busy = state_reg.tx_state != CH_IDLE;
        rx_busy = state_reg.rx_state != CH_IDLE;

        // one-cycle strobes towards the address registers and the shifter
        // the reset strobes are what makes the control bits self-clearing:
        // nothing is stored, so the bits always read back as zero
        state_next.addr_latch = {tx_set, rx_set}; // [R15]
        state_next.tx_rst = do_tx_rst; // [R13]
        state_next.rx_rst = do_rx_rst; // [R14]
        state_next.save_pulse = 1'b0;

        // transmit offset counts fetched bytes of the active buffer only;
        // fetch pulses seen while idle are dropped
        // the offset is 13 bits wide and wraps; the end address bounds it
        // long before that in practice
        if (tx_busy && tx_byte_fetched) begin
            state_next.tx_cnt = state_reg.tx_cnt + 13'h1; // [R1]
        end

        // transmit buffer end: drop its load bit and hand over
        if (tx_buf_done) begin
            case (state_reg.tx_state)
                CH_BUF_A: begin
                    state_next.tx_load[0] = 1'b0; // [R17]
                    if (state_reg.tx_load[1]) begin
                        state_next.tx_state = CH_BUF_B; // [R20]
                    end else begin
                        state_next.tx_state = CH_IDLE; // [R20]
                    end
                    // the offset restarts for the buffer that takes over
                    state_next.tx_cnt = '0;
                end
                CH_BUF_B: begin
                    state_next.tx_load[1] = 1'b0; // [R17]
                    if (state_reg.tx_load[0]) begin
                        state_next.tx_state = CH_BUF_A; // [R20]
                    end else begin
                        state_next.tx_state = CH_IDLE; // [R20]
                    end
                    // the offset restarts for the buffer that takes over
                    state_next.tx_cnt = '0;
                end
                default: begin
                    // a done pulse with no active buffer is ignored
                    state_next.tx_state = state_reg.tx_state;
                end
            endcase
        end

        // loads are or'ed in after the done clear, so a load written in the
        // cycle its buffer finishes keeps the buffer pending
        state_next.tx_load = state_next.tx_load | tx_set; // [R15]

        // an idle channel starts on a loaded buffer, a before b
        // this also restarts a channel whose reload came with its done
        if (state_next.tx_state == CH_IDLE) begin
            if (state_next.tx_load[0]) begin
                state_next.tx_state = CH_BUF_A; // [R16]
            end else if (state_next.tx_load[1]) begin
                state_next.tx_state = CH_BUF_B; // [R16]
            end
        end

        // any load restarts the offset, even while the other buffer runs
        if (tx_set != 2'h0) begin
            state_next.tx_cnt = '0; // [R2]
        end

        // transmit reset beats every other event in the same cycle
        // it also drops a pending load, so software must reload after it
        if (do_tx_rst) begin
            state_next.tx_state = CH_IDLE; // [R13]
            state_next.tx_load = 2'h0; // [R13]
            state_next.tx_cnt = '0; // [R2]
        end

        // receive error marks land on the buffer that takes the byte
        // a byte arriving while idle is not counted against any buffer
        if (rx_byte.valid && rx_busy) begin
            if (rx_byte.frame_err) begin
                state_next.frame_err = state_reg.frame_err | rx_sel; // [R5]
            end
            if (rx_byte.parity_err) begin
                state_next.parity_err = state_reg.parity_err | rx_sel; // [R6]
            end
        end

        // an overflow with both buffers unloaded has nowhere to go yet;
        // it is held here until a buffer drains the fifo
        // an overflow while a buffer is loaded is marked by the fifo itself
        // on the byte that carries it, through the overrun mark below
        if (rx_fifo_overflow && (state_reg.rx_load == 2'h0)) begin
            state_next.overrun_pending = 1'b1; // [R9]
        end

        // the buffer that drains the fifo takes the overrun mark
        if (rx_busy &&
            ((rx_byte.valid && rx_byte.overrun) || state_reg.overrun_pending)) begin
            state_next.overrun = state_reg.overrun | rx_sel; // [R9]
            state_next.overrun_pending = 1'b0;
        end

        // deassertion is a rising select level while a buffer is active;
        // outside slave mode the select pin means nothing here
        if (spi_slave_mode && slave_select_n &&
            !state_reg.ssel_seen_reg && rx_busy) begin
            ssel_fall = 1'b1;
        end

        // first deassertion saves the count, later ones only mark it stale
        // code bit 0 names the buffer, bit 2 says the count went stale
        // only the first save raises the capture strobe
        if (ssel_fall) begin
            if (state_reg.saved_status == SAVED_NONE) begin
                state_next.saved_status = SAVED_ONCE | {2'h0, rx_b}; // [R3]
                state_next.save_pulse = 1'b1; // [R19]
            end else begin
                state_next.saved_status = state_reg.saved_status | SAVED_MANY; // [R19]
            end
        end

        // select level kept for the edge test in the next cycle
        state_next.ssel_seen_reg = slave_select_n;

        // receive buffer end, same hand-over as on the transmit side
        // a done and a reload of the same buffer in one cycle: the load is
        // or'ed in below and keeps that buffer pending
        if (rx_buf_done) begin
            case (state_reg.rx_state)
                CH_BUF_A: begin
                    state_next.rx_load[0] = 1'b0; // [R17]
                    if (state_reg.rx_load[1]) begin
                        state_next.rx_state = CH_BUF_B; // [R20]
                    end else begin
                        state_next.rx_state = CH_IDLE; // [R20]
                    end
                end
                CH_BUF_B: begin
                    state_next.rx_load[1] = 1'b0; // [R17]
                    if (state_reg.rx_load[0]) begin
                        state_next.rx_state = CH_BUF_A; // [R20]
                    end else begin
                        state_next.rx_state = CH_IDLE; // [R20]
                    end
                end
                default: begin
                    // nothing to finish while idle
                    state_next.rx_state = state_reg.rx_state;
                end
            endcase
        end

        // receive loads, again after the done clear
        state_next.rx_load = state_next.rx_load | rx_set; // [R15]

        // an idle receive channel also prefers buffer a
        if (state_next.rx_state == CH_IDLE) begin
            if (state_next.rx_load[0]) begin
                state_next.rx_state = CH_BUF_A; // [R16]
            end else if (state_next.rx_load[1]) begin
                state_next.rx_state = CH_BUF_B; // [R16]
            end
        end

        // a reload opens a new buffer and wipes its own flags only;
        // the clear is applied last, so it wins over a mark in the same cycle
        state_next.frame_err = state_next.frame_err & ~rx_set; // [R7]
        state_next.parity_err = state_next.parity_err & ~rx_set; // [R7]
        state_next.overrun = state_next.overrun & ~rx_set; // [R10]

        // any receive load starts a fresh saved-count record
        // reload and save in one cycle: the clear wins, new buffer, new record
        if (rx_set != 2'h0) begin
            state_next.saved_status = SAVED_NONE; // [R4]
        end

        // receive reset clears the whole receive side and its status
        // it also drops a pending load, so software must reload after it
        if (do_rx_rst) begin
            state_next.rx_state = CH_IDLE; // [R14]
            state_next.rx_load = 2'h0; // [R14]
            state_next.frame_err = 2'h0; // [R7]
            state_next.parity_err = 2'h0; // [R7]
            state_next.overrun = 2'h0; // [R10]
            state_next.overrun_pending = 1'b0;
            state_next.saved_status = SAVED_NONE; // [R4]
        end

        // the second controller has no error marks to report
        // a build-time choice: the flags stay zero in every state
        if (SECOND_CONTROLLER) begin
            state_next.frame_err = 2'h0; // [R8]
            state_next.parity_err = 2'h0; // [R8]
        end

        // active flags registered from the next state, so the outputs and
        // the status bits come straight from flip-flops with no decode
        state_next.act[3] = state_next.tx_state == CH_BUF_B; // [R11]
        state_next.act[2] = state_next.tx_state == CH_BUF_A; // [R11]
        state_next.act[1] = state_next.rx_state == CH_BUF_B; // [R12]
        state_next.act[0] = state_next.rx_state == CH_BUF_A; // [R12]

        // status word built from the registered state; reserved bits stay zero
        status_word[ST_SAVED_LSB +: 3] = state_reg.saved_status; // [R3]
        status_word[ST_FE_A +: 2] = state_reg.frame_err; // [R5]
        status_word[ST_PE_A +: 2] = state_reg.parity_err; // [R6]
        status_word[ST_OVR_A +: 2] = state_reg.overrun; // [R9]
        status_word[ST_TX_ACT_A +: 2] = state_reg.act[3:2]; // [R11]
        status_word[ST_RX_ACT_A +: 2] = state_reg.act[1:0]; // [R12]

        // read data stand one cycle after the strobe and are zero otherwise,
        // so a stale value can never be mistaken for a fresh read
        state_next.rdata = '0;
        if (reg_req.rd) begin
            case (reg_req.addr)
                TX_CNT_OFFSET: begin
                    state_next.rdata = {19'h0, state_reg.tx_cnt}; // [R1]
                end
                STATUS_OFFSET: begin
                    state_next.rdata = status_word;
                end
                CONTROL_OFFSET: begin
                    // reset bits hold nothing and read back as zero
                    state_next.rdata = {28'h0, state_reg.tx_load,
                                        state_reg.rx_load}; // [R18]
                end
                default: begin
                    // unmapped addresses read as zero
                    state_next.rdata = UNMAPPED_READ_VALUE;
                end
            endcase
        end
    end

    // one register bank, synchronous reset
    // select level starts high so release gives no false deassertion
    // the whole state moves as one struct, so no field can be missed
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            state_reg <= '0;
            state_reg.ssel_seen_reg <= 1'b1;
        end else begin
            state_reg <= state_next;
        end
    end

    // outputs straight from the register bank
    // none of these is decoded after the flops
    assign rdata = state_reg.rdata;
    assign addr_latch = state_reg.addr_latch;
    assign tx_active_a = state_reg.act[2];
    assign tx_active_b = state_reg.act[3];
    assign rx_active_a = state_reg.act[0];
    assign rx_active_b = state_reg.act[1];
    assign tx_chan_reset = state_reg.tx_rst;
    assign rx_chan_reset = state_reg.rx_rst;
    assign save_rx_count = state_reg.save_pulse;

endmodule : serial_ping_pong_dma_ctrl

// ### sim/dma_ctrl_chk.sv
// checker: port-level assertions on the ping-pong dma control
module dma_ctrl_chk
    import dma_ctrl_pkg::*;
(
    input wire logic clk,
    input wire logic rst_n,
    input wire reg_req_s reg_req,
    input wire logic [31:0] rdata,
    input wire logic tx_buf_done,
    input wire logic [3:0] addr_latch,
    input wire logic tx_active_a,
    input wire logic tx_active_b,
    input wire logic rx_active_a,
    input wire logic rx_active_b,
    input wire logic tx_chan_reset,
    input wire logic rx_chan_reset
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!rst_n);
    // control write with one given bit set
    sequence s_ctl(int b);
        reg_req.wr && reg_req.addr == CONTROL_OFFSET && reg_req.wdata[b];
    endsequence
    // both tx buffers loaded at once while idle
    sequence s_both_tx;
        s_ctl(2) ##0 (reg_req.wdata[3] && !tx_active_a && !tx_active_b);
    endsequence
    property p_st_mirror;
        reg_req.rd && reg_req.addr == STATUS_OFFSET |=>
            rdata[3:0] == $past({tx_active_b, tx_active_a, rx_active_b, rx_active_a});
    endproperty
    property p_tx_one;
        !(tx_active_a && tx_active_b);
    endproperty
    property p_rx_one;
        !(rx_active_a && rx_active_b);
    endproperty
    property p_latch;
        s_ctl(2) |=> addr_latch[2];
    endproperty
    property p_tx_dma_reset;
        s_ctl(5) |=> tx_chan_reset && !tx_active_a && !tx_active_b;
    endproperty
    property p_rx_dma_reset;
        s_ctl(4) |=> rx_chan_reset && !rx_active_a && !rx_active_b;
    endproperty
    property p_a_first;
        s_both_tx |=> tx_active_a && !tx_active_b;
    endproperty
    // no reload in the same cycle, so the finished buffer must drop
    property p_done;
        tx_buf_done && tx_active_a && !reg_req.wr |=> !tx_active_a;
    endproperty
    a_st_mirror: assert property (p_st_mirror) else $error("status flags mismatch");
    a_tx_one: assert property (p_tx_one) else $error("two tx buffers active");
    a_rx_one: assert property (p_rx_one) else $error("two rx buffers active");
    a_latch: assert property (p_latch) else $error("no address latch");
    a_tx_dma_reset: assert property (p_tx_dma_reset) else $error("tx reset missed");
    a_rx_dma_reset: assert property (p_rx_dma_reset) else $error("rx reset missed");
    a_a_first: assert property (p_a_first) else $error("buffer b first");
    a_done: assert property (p_done) else $error("done buffer still active");
endmodule : dma_ctrl_chk

bind serial_ping_pong_dma_ctrl dma_ctrl_chk dma_ctrl_chk_inst (.clk, .rst_n, .reg_req,
    .rdata, .tx_buf_done, .addr_latch, .tx_active_a, .tx_active_b, .rx_active_a,
    .rx_active_b, .tx_chan_reset, .rx_chan_reset);

// ### sim/serial_fifo_model.sv
// far-side model: fifo and ram-bus event pulses into the dma control
module serial_fifo_model
    import dma_ctrl_pkg::*;
(
    input wire logic clk,
    output logic tx_byte_fetched,
    output logic tx_buf_done,
    output rx_byte_s rx_byte,
    output logic rx_buf_done,
    output logic rx_fifo_overflow,
    output logic slave_select_n
);
    timeunit 1ns;
    timeprecision 1ps;
    // quiet lines, slave selected until a pulse deasserts it
    initial begin
        {tx_byte_fetched, tx_buf_done, rx_byte, rx_buf_done} = '0;
        {rx_fifo_overflow, slave_select_n} = '0;
    end
    // n back-to-back fetches, then optionally end the buffer
    task automatic tx(input int n, input bit fin);
        repeat (n) begin
            @(posedge clk);
            tx_byte_fetched <= 1'b1;
        end
        @(posedge clk);
        tx_byte_fetched <= 1'b0;
        tx_buf_done <= fin;
        @(posedge clk);
        tx_buf_done <= 1'b0;
    endtask : tx
    // one received byte with its marks, or a buffer end
    task automatic rx(input bit v, input bit fe, input bit pe, input bit fin);
        @(posedge clk);
        rx_byte <= '{v, fe, pe, 1'b0};
        rx_buf_done <= fin;
        @(posedge clk);
        rx_byte <= '0;
        rx_buf_done <= 1'b0;
    endtask : rx
    // one-cycle overflow, or one deassertion of slave select
    task automatic pulse(input bit ovf);
        @(posedge clk);
        rx_fifo_overflow <= ovf;
        slave_select_n <= !ovf;
        @(posedge clk);
        rx_fifo_overflow <= 1'b0;
        slave_select_n <= 1'b0;
    endtask : pulse
endmodule : serial_fifo_model

// ### sim/serial_ping_pong_dma_ctrl_tb_top.sv
// testbench: register-call sequences against the ping-pong dma control
module serial_ping_pong_dma_ctrl_tb_top
    import dma_ctrl_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    reg_req_s reg_req = '0;
    logic [31:0] rdata;
    logic tx_byte_fetched, tx_buf_done, rx_buf_done, rx_fifo_overflow, slave_select_n;
    rx_byte_s rx_byte;
    logic slave_mode = 1'b1;
    logic save_pulse;
    int saves = 0;
    int err_count = 0;
    int check_count = 0;
    int cyc = 0;
    logic [15:0] offs [4] = '{TX_CNT_OFFSET, STATUS_OFFSET, CONTROL_OFFSET, 16'hc834};

    serial_fifo_model serial_fifo_model_inst (.clk, .tx_byte_fetched, .tx_buf_done,
        .rx_byte, .rx_buf_done, .rx_fifo_overflow, .slave_select_n);
    // slave mode on for most tests, dropped at the end to show it gates the save
    serial_ping_pong_dma_ctrl serial_ping_pong_dma_ctrl_inst (.clk, .rst_n, .reg_req,
        .rdata, .tx_byte_fetched, .tx_buf_done, .rx_byte, .rx_buf_done, .rx_fifo_overflow,
        .spi_slave_mode(slave_mode), .slave_select_n, .addr_latch(), .tx_active_a(),
        .tx_active_b(), .rx_active_a(), .rx_active_b(), .tx_chan_reset(),
        .rx_chan_reset(), .save_rx_count(save_pulse));
    // capture strobes counted: one per first deassertion only
    always @(posedge clk) begin
        if (save_pulse === 1'b1) saves <= saves + 1;
    end

    initial begin
        forever #5 clk = ~clk;
    end
    // hang guard, far above the hundred or so cycles used
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == 3000) begin
            err_count++;
            wrap_up();
        end
    end

    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        check_count++;
        if (got !== exp) begin
            err_count++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : check
    // one-cycle strobes with an idle cycle after, so no signal is driven twice per step
    task automatic wr(input logic [15:0] a, input logic [31:0] d);
        @(posedge clk);
        reg_req <= '{a, d, 1'b1, 1'b0};
        @(posedge clk);
        reg_req <= '0;
    endtask : wr
    task automatic rd(input logic [15:0] a, input logic [31:0] exp);
        @(posedge clk);
        reg_req <= '{a, 32'h0, 1'b0, 1'b1};
        @(posedge clk);
        reg_req <= '0;
        #1 check(rdata, exp);
    endtask : rd
    task automatic wrap_up();
        $display("checks %0d errors %0d", check_count, err_count);
        if (err_count == 0 && check_count > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask : wrap_up

    initial begin
        repeat (6) @(posedge clk);
        rst_n <= 1'b1;
        for (int i = 0; i < 4; i++) rd(offs[i], REG_RESET_VALUE);
        wr(CONTROL_OFFSET, 32'hc);
        rd(STATUS_OFFSET, 32'h4);
        rd(CONTROL_OFFSET, 32'hc);
        serial_fifo_model_inst.tx(3, 1'b0);
        rd(TX_CNT_OFFSET, 32'h3);
        serial_fifo_model_inst.tx(0, 1'b1);
        rd(STATUS_OFFSET, 32'h8);
        rd(TX_CNT_OFFSET, 32'h0);
        wr(CONTROL_OFFSET, 32'h0);
        rd(CONTROL_OFFSET, 32'h8);
        serial_fifo_model_inst.tx(2, 1'b0);
        wr(CONTROL_OFFSET, 32'h20);
        rd(TX_CNT_OFFSET, 32'h0);
        rd(CONTROL_OFFSET, 32'h0);
        // receive: errors per buffer, hand-over, reload, saved-count codes
        wr(CONTROL_OFFSET, 32'h3);
        serial_fifo_model_inst.rx(1'b1, 1'b1, 1'b1, 1'b0);
        rd(STATUS_OFFSET, 32'h141);
        serial_fifo_model_inst.rx(1'b0, 1'b0, 1'b0, 1'b1);
        serial_fifo_model_inst.rx(1'b1, 1'b0, 1'b1, 1'b0);
        rd(STATUS_OFFSET, 32'h1c2);
        wr(CONTROL_OFFSET, 32'h1);
        rd(STATUS_OFFSET, 32'h82);
        serial_fifo_model_inst.pulse(1'b0);
        rd(STATUS_OFFSET, 32'hc82);
        serial_fifo_model_inst.pulse(1'b0);
        rd(STATUS_OFFSET, 32'h1c82);
        check(saves, 32'h1);
        wr(CONTROL_OFFSET, 32'h10);
        rd(STATUS_OFFSET, 32'h0);
        // overflow with nothing loaded lands on the next buffer
        serial_fifo_model_inst.pulse(1'b1);
        wr(CONTROL_OFFSET, 32'h2);
        serial_fifo_model_inst.rx(1'b1, 1'b0, 1'b0, 1'b0);
        rd(STATUS_OFFSET, 32'h22);
        serial_fifo_model_inst.rx(1'b0, 1'b0, 1'b0, 1'b1);
        wr(CONTROL_OFFSET, 32'h2);
        rd(STATUS_OFFSET, 32'h2);
        @(posedge clk) slave_mode <= 1'b0;
        serial_fifo_model_inst.pulse(1'b0);
        rd(STATUS_OFFSET, 32'h2);
        check(saves, 32'h1);
        wrap_up();
    end
endmodule : serial_ping_pong_dma_ctrl_tb_top
